// >>> tof_global_control.sv
// global control register with link-side word access and calibration words
`timescale 1ns/10ps
`default_nettype none
module tof_global_control (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clock_enable,
	input wire logic capture_done,
	input wire logic link_clock,
	input wire logic link_rst_n,
	input wire logic link_valid,
	input wire logic link_write,
	input wire logic link_cont,
	input wire logic [7:0] link_addr,
	input wire logic [23:0] link_wdata,
	output logic link_busy,
	output logic link_done,
	output logic [23:0] link_rdata,
	output logic capture_start,
	output logic slave_forward_enable,
	output logic aux_host_bypass,
	output logic continuous_slave_access,
	output logic soft_reset_pulse
);
	typedef enum logic [1:0] {S_IDLE, S_ACCESS, S_REPLY} access_state_t;
	// ==========================================
	// link domain: request capture and reply pickup
	logic link_req_tgl, hold_write, hold_cont, ack_s1, ack_s2, ack_s3, ack_seen, ack_event;
	logic [7:0] hold_addr;
	logic [23:0] hold_wdata;
	// core domain signals
	logic ack_tgl, req_s1, req_s2, req_s3, req_seen, req_event;
	logic acc_write, acc_refused, global_write, soft_write, calib_write;
	logic [7:0] acc_addr, last_addr;
	logic [23:0] reply_data, acc_wdata, global_control, mem_rdata;
	logic [4:0] acc_slot;
	access_state_t state;
	assign ack_event = (ack_s2 == ack_s3) && (ack_s3 != ack_seen);
	always_ff @(posedge link_clock)
	begin
		if (!link_rst_n)
		begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
			ack_s3 <= 1'b0;
		end
		else
		begin
			ack_s1 <= ack_tgl;
			ack_s2 <= ack_s1;
			ack_s3 <= ack_s2;
		end
	end

	always_ff @(posedge link_clock)
	begin
		if (!link_rst_n)
		begin
			link_busy <= 1'b0;
			link_done <= 1'b0;
			link_rdata <= tof_ctrl_pkg::ZERO_WORD;
			link_req_tgl <= 1'b0;
			ack_seen <= 1'b0;
			hold_write <= 1'b0;
			hold_cont <= 1'b0;
			hold_addr <= tof_ctrl_pkg::GLOBAL_ADDR;
			hold_wdata <= tof_ctrl_pkg::ZERO_WORD;
		end
		else
		begin
			link_done <= 1'b0;
			if (ack_event)
			begin
				ack_seen <= ack_s3;
				link_rdata <= reply_data;
				link_done <= 1'b1;
				link_busy <= 1'b0;
			end
			else if (link_valid && !link_busy)
			begin
				hold_write <= link_write;
				hold_cont <= link_cont;
				hold_addr <= link_addr;
				hold_wdata <= link_wdata;
				link_req_tgl <= ~link_req_tgl;
				link_busy <= 1'b1;
			end
		end
	end

	// ==========================================
	// core domain: request detection
	assign req_event = (req_s2 == req_s3) && (req_s3 != req_seen);

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
		end
		else if (clock_enable)
		begin
			req_s1 <= link_req_tgl;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
		end
	end

	assign acc_slot = tof_ctrl_pkg::calib_slot(acc_addr);
	assign global_write = (state == S_ACCESS) && acc_write && !acc_refused
		&& (acc_addr == tof_ctrl_pkg::GLOBAL_ADDR);
	assign soft_write = global_write && acc_wdata[tof_ctrl_pkg::BIT_SOFT_RESET];
	assign calib_write = (state == S_ACCESS) && acc_write && !acc_refused && acc_slot[4];

	// ==========================================
	// access sequencer
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state <= S_IDLE;
			req_seen <= 1'b0;
			ack_tgl <= 1'b0;
			acc_addr <= tof_ctrl_pkg::GLOBAL_ADDR;
			acc_write <= 1'b0;
			acc_refused <= 1'b0;
			acc_wdata <= tof_ctrl_pkg::ZERO_WORD;
			reply_data <= tof_ctrl_pkg::ZERO_WORD;
		end
		else if (clock_enable)
		begin
			case (state)
				S_IDLE:
				begin
					if (req_event)
					begin
						req_seen <= req_s3;
						acc_addr <= hold_cont ? 8'(last_addr + tof_ctrl_pkg::ADDR_STEP) : hold_addr;
						acc_refused <= hold_cont && !continuous_slave_access;
						acc_write <= hold_write;
						acc_wdata <= hold_wdata;
						state <= S_ACCESS;
					end
				end
				S_ACCESS:
				begin
					state <= S_REPLY;
				end
				S_REPLY:
				begin
					// read back of the selected word
					reply_data <= acc_refused ? tof_ctrl_pkg::ZERO_WORD
						: (acc_addr == tof_ctrl_pkg::GLOBAL_ADDR) ? global_control
						: acc_slot[4] ? mem_rdata : tof_ctrl_pkg::ZERO_WORD;
					ack_tgl <= ~ack_tgl;
					state <= S_IDLE;
				end
				default:
				begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// continuous access remembers the last word touched
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			last_addr <= tof_ctrl_pkg::GLOBAL_ADDR;
		end
		else if (clock_enable)
		begin
			if (soft_write)
			begin
				last_addr <= tof_ctrl_pkg::GLOBAL_ADDR;
			end
			else if (state == S_ACCESS && !acc_refused)
			begin
				last_addr <= acc_addr;
			end
		end
	end

	// ==========================================
	// global control register
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			global_control <= tof_ctrl_pkg::GLOBAL_RESET;
		end
		else if (clock_enable)
		begin
			if (soft_write)
			begin
				global_control <= tof_ctrl_pkg::GLOBAL_RESET;
			end
			else if (global_write)
			begin
				// reserved bits and soft reset bit are not stored
				global_control <= acc_wdata & tof_ctrl_pkg::GLOBAL_WRITE_MASK;
			end
			else if (capture_done && global_control[tof_ctrl_pkg::BIT_MONOSHOT])
			begin
				global_control[tof_ctrl_pkg::BIT_MONOSHOT] <= 1'b0;
			end
		end
	end

	assign slave_forward_enable = global_control[tof_ctrl_pkg::BIT_FORWARD];
	assign aux_host_bypass = global_control[tof_ctrl_pkg::BIT_BYPASS];
	assign continuous_slave_access = global_control[tof_ctrl_pkg::BIT_CONT];

	// ==========================================
	// capture trigger and soft reset pulses
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			capture_start <= 1'b0;
			soft_reset_pulse <= 1'b0;
		end
		else if (clock_enable)
		begin
			capture_start <= global_write && !soft_write && acc_wdata[tof_ctrl_pkg::BIT_MONOSHOT];
			soft_reset_pulse <= soft_write;
		end
	end

	calib_word_store #(
		.WIDTH(tof_ctrl_pkg::DATA_W),
		.DEPTH(tof_ctrl_pkg::CALIB_WORDS),
		.IDX_W(tof_ctrl_pkg::CALIB_IDX_W)
	) u_calib (
		.clock(clock),
		.clock_enable(clock_enable),
		.write_enable(calib_write),
		.index(acc_slot[3:0]),
		.write_data(acc_wdata),
		.read_data(mem_rdata)
	);
	// ==========================================
	// assertions
	sequence s_trigger_write;
		clock_enable && global_write && !soft_write && acc_wdata[tof_ctrl_pkg::BIT_MONOSHOT];
	endsequence
	sequence s_trigger_running;
		capture_start && global_control[tof_ctrl_pkg::BIT_MONOSHOT];
	endsequence
	property p_trigger_start;
		@(posedge clock) disable iff (!rst_n)
		s_trigger_write |=> s_trigger_running ##1 (!capture_start || !$past(clock_enable));
	endproperty
	a_trigger_start: assert property (p_trigger_start) else $error("capture trigger write did not start capture");
	property p_trigger_clear;
		@(posedge clock) disable iff (!rst_n)
		clock_enable && capture_done && global_control[tof_ctrl_pkg::BIT_MONOSHOT] && !global_write
			|=> !global_control[tof_ctrl_pkg::BIT_MONOSHOT];
	endproperty
	a_trigger_clear: assert property (p_trigger_clear) else $error("capture trigger not cleared on completion");
	property p_forward_set;
		@(posedge clock) disable iff (!rst_n)
		clock_enable && global_write && !soft_write && acc_wdata[tof_ctrl_pkg::BIT_FORWARD]
			|=> slave_forward_enable && !aux_host_bypass == !$past(acc_wdata[tof_ctrl_pkg::BIT_BYPASS]);
	endproperty
	a_forward_set: assert property (p_forward_set) else $error("forwarding enable not taken from write");
	property p_bypass_set;
		@(posedge clock) disable iff (!rst_n)
		clock_enable && global_write && !soft_write && acc_wdata[tof_ctrl_pkg::BIT_BYPASS]
			|=> aux_host_bypass [*2] or (aux_host_bypass ##1 (global_write || soft_write));
	endproperty
	a_bypass_set: assert property (p_bypass_set) else $error("bypass not held after write");
	property p_cont_step;
		@(posedge clock) disable iff (!rst_n)
		clock_enable && state == S_IDLE && req_event && hold_cont && continuous_slave_access
			|=> !acc_refused && acc_addr == 8'($past(last_addr) + tof_ctrl_pkg::ADDR_STEP);
	endproperty
	a_cont_step: assert property (p_cont_step) else $error("continuous access did not step address");
	property p_cont_refuse;
		@(posedge clock) disable iff (!rst_n)
		clock_enable && state == S_ACCESS && acc_refused && !capture_done |=> $stable(global_control);
	endproperty
	a_cont_refuse: assert property (p_cont_refuse) else $error("refused continuation changed register");
	property p_soft_reset;
		@(posedge clock) disable iff (!rst_n)
		clock_enable && soft_write
			|=> global_control == tof_ctrl_pkg::GLOBAL_RESET && soft_reset_pulse && !capture_start;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not restore defaults");
	property p_reset_zero;
		@(posedge clock) disable iff (!rst_n)
		$rose(rst_n) |-> global_control == tof_ctrl_pkg::GLOBAL_RESET && !capture_start;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("global control not zero after reset");
	property p_read_back;
		@(posedge clock) disable iff (!rst_n)
		clock_enable && state == S_REPLY && !acc_refused && acc_addr == tof_ctrl_pkg::GLOBAL_ADDR
			|=> reply_data == $past(global_control) && ack_tgl != $past(ack_tgl);
	endproperty
	a_read_back: assert property (p_read_back) else $error("global control read back wrong");
	property p_link_take;
		@(posedge link_clock) disable iff (!link_rst_n)
		link_valid && !link_busy && !ack_event |=> link_busy && link_req_tgl != $past(link_req_tgl);
	endproperty
	a_link_take: assert property (p_link_take) else $error("link request not taken");
	property p_freeze;
		@(posedge clock) disable iff (!rst_n)
		!clock_enable |=> $stable(state) && $stable(global_control) && $stable(reply_data)
			&& $stable(ack_tgl) && $stable(last_addr) && $stable(capture_start);
	endproperty
	a_freeze: assert property (p_freeze) else $error("core state moved while clock enable low");
endmodule
`default_nettype wire

// >>> tof_ctrl_pkg.sv
// constants for the global control register and calibration word map
package tof_ctrl_pkg;

	// ==========================================
	// bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 24;
	localparam int CALIB_WORDS = 12;
	localparam int CALIB_IDX_W = 4;

	// ==========================================
	// register offsets
	localparam logic [7:0] GLOBAL_ADDR = 8'h00;
	localparam logic [7:0] CALIB_AB_ADDR = 8'hab;
	localparam logic [7:0] CALIB_AC_ADDR = 8'hac;
	localparam logic [7:0] CALIB_AD_ADDR = 8'had;
	localparam logic [7:0] CALIB_AE_ADDR = 8'hae;
	localparam logic [7:0] CALIB_AF_ADDR = 8'haf;
	localparam logic [7:0] CALIB_B0_ADDR = 8'hb0;
	localparam logic [7:0] CALIB_B1_ADDR = 8'hb1;
	localparam logic [7:0] CALIB_B2_ADDR = 8'hb2;
	localparam logic [7:0] PWL_COEFFS_ADDR = 8'hb4;
	localparam logic [7:0] PWL_SCALE_ADDR = 8'hb5;
	localparam logic [7:0] PWL_KNEES_LO_ADDR = 8'hb8;
	localparam logic [7:0] PWL_KNEE_HI_ADDR = 8'hb9;
	localparam logic [7:0] ADDR_STEP = 8'h01;

	// ==========================================
	// global control fields
	localparam int BIT_MONOSHOT = 23;
	localparam int BIT_FORWARD = 22;
	localparam int BIT_BYPASS = 21;
	localparam int BIT_CONT = 6;
	localparam int BIT_SOFT_RESET = 0;
	localparam logic [23:0] GLOBAL_RESET = 24'h000000;
	localparam logic [23:0] GLOBAL_WRITE_MASK = 24'he00040;
	localparam logic [23:0] ZERO_WORD = 24'h000000;

	// map an offset onto a calibration word slot: {hit, index}
	function automatic logic [4:0] calib_slot(input logic [7:0] addr);
		logic [4:0] slot;
		slot = 5'h00;
		case (addr)
			CALIB_AB_ADDR: slot = 5'h10;
			CALIB_AC_ADDR: slot = 5'h11;
			CALIB_AD_ADDR: slot = 5'h12;
			CALIB_AE_ADDR: slot = 5'h13;
			CALIB_AF_ADDR: slot = 5'h14;
			CALIB_B0_ADDR: slot = 5'h15;
			CALIB_B1_ADDR: slot = 5'h16;
			CALIB_B2_ADDR: slot = 5'h17;
			PWL_COEFFS_ADDR: slot = 5'h18;
			PWL_SCALE_ADDR: slot = 5'h19;
			PWL_KNEES_LO_ADDR: slot = 5'h1a;
			PWL_KNEE_HI_ADDR: slot = 5'h1b;
			default: slot = 5'h00;
		endcase
		return slot;
	endfunction

endpackage

// >>> calib_word_store.sv
// small word memory for calibration coefficients, registered read
`timescale 1ns/10ps
`default_nettype none
module calib_word_store #(
	parameter int WIDTH = tof_ctrl_pkg::DATA_W,
	parameter int DEPTH = tof_ctrl_pkg::CALIB_WORDS,
	parameter int IDX_W = tof_ctrl_pkg::CALIB_IDX_W
) (
	input wire logic clock,
	input wire logic clock_enable,
	input wire logic write_enable,
	input wire logic [IDX_W-1:0] index,
	input wire logic [WIDTH-1:0] write_data,
	output logic [WIDTH-1:0] read_data
);

	logic [WIDTH-1:0] words [DEPTH];

	always_ff @(posedge clock)
	begin
		if (clock_enable && write_enable && (32'(index) < DEPTH))
		begin
			words[index] <= write_data;
		end
	end

	always_ff @(posedge clock)
	begin
		if (clock_enable)
		begin
			if (write_enable && (32'(index) < DEPTH))
			begin
				// a write replies with the word just written
				read_data <= write_data;
			end
			else if (32'(index) < DEPTH)
			begin
				read_data <= words[index];
			end
			else
			begin
				read_data <= '0;
			end
		end
	end

endmodule
`default_nettype wire

// >>> tof_link_host.sv
// link-side host model with a capture engine stand-in
`timescale 1ns/10ps
`default_nettype none
module tof_link_host #(
	parameter bit AUX_FLOATING = 1'b0
) (
	input wire logic clock,
	input wire logic link_clock,
	input wire logic link_busy,
	input wire logic link_done,
	input wire logic capture_start,
	output logic capture_done,
	output logic link_valid,
	output logic link_write,
	output logic link_cont,
	output logic [7:0] link_addr,
	output logic [23:0] link_wdata
);
	int cap_delay = 40;
	int cap_wait = 0;
	logic raw = 1'b0;
	initial
	begin
		capture_done = 1'b0;
		link_valid = 1'b0;
		link_write = 1'b0;
		link_cont = 1'b0;
		link_addr = 8'h00;
		link_wdata = 24'h000000;
	end
	// ==========================================
	// capture engine: ends a capture cap_delay cycles after start
	always @(posedge clock)
	begin
		capture_done <= (cap_wait == 1);
		if (capture_start === 1'b1)
			cap_wait <= cap_delay;
		else if (cap_wait > 0)
			cap_wait <= cap_wait - 1;
	end
	// ==========================================
	// one word access, request held until taken
	task automatic access(input logic wr, input logic cont, input logic [7:0] a, input logic [23:0] data);
		int n;
		logic [23:0] d;
		n = 0;
		d = data;
		if (!raw && a == tof_ctrl_pkg::GLOBAL_ADDR)
			d = data & 24'he00041;
		if (AUX_FLOATING && a == tof_ctrl_pkg::GLOBAL_ADDR)
			d[22] = 1'b1;
		@(posedge link_clock);
		link_valid <= 1'b1;
		link_write <= wr;
		link_cont <= cont;
		link_addr <= a;
		link_wdata <= d;
		@(posedge link_clock);
		while (link_busy === 1'b1 && n < 40)
		begin
			@(posedge link_clock);
			n++;
		end
		// released lines show the inverse, not the old value
		link_valid <= 1'b0;
		link_write <= ~wr;
		link_cont <= ~cont;
		link_addr <= ~a;
		link_wdata <= ~d;
		n = 0;
		while (link_done !== 1'b1 && n < 40)
		begin
			@(posedge link_clock);
			n++;
		end
	endtask
endmodule
`default_nettype wire

// >>> test_tof_global_control.sv
// self-checking bench for the global control register
`timescale 1ns/10ps
`default_nettype none
module test_tof_global_control;
	logic clock = 1'b0;
	logic link_clock = 1'b0;
	logic rst_n = 1'b0;
	logic link_rst_n = 1'b0;
	logic clock_enable = 1'b1;
	logic capture_done, link_valid, link_write, link_cont, link_busy, link_done, capture_start;
	logic slave_forward_enable, aux_host_bypass, continuous_slave_access, soft_reset_pulse;
	logic [7:0] link_addr;
	logic [23:0] link_wdata, link_rdata, v;
	logic [23:0] exp_q[$];
	logic [23:0] calib[12];
	logic [7:0] caddr[12] = '{8'hab, 8'hac, 8'had, 8'hae, 8'haf, 8'hb0, 8'hb1, 8'hb2, 8'hb4, 8'hb5, 8'hb8, 8'hb9};
	int err_count = 0;
	int check_count = 0;
	int starts = 0;
	int resets = 0;
	bit ce_rand = 1'b0;
	localparam logic [7:0] G = tof_ctrl_pkg::GLOBAL_ADDR;

	tof_global_control tof_global_control_inst (.clock, .rst_n, .clock_enable, .capture_done, .link_clock,
		.link_rst_n, .link_valid, .link_write, .link_cont, .link_addr, .link_wdata, .link_busy, .link_done,
		.link_rdata, .capture_start, .slave_forward_enable, .aux_host_bypass, .continuous_slave_access,
		.soft_reset_pulse);
	tof_link_host tof_link_host_inst (.clock, .link_clock, .link_busy, .link_done, .capture_start,
		.capture_done, .link_valid, .link_write, .link_cont, .link_addr, .link_wdata);

	initial
		forever #2 clock = ~clock;
	initial
	begin
		#3.3;
		forever #7.5 link_clock = ~link_clock;
	end

	task check(input logic [23:0] seen, input logic [23:0] want);
		check_count++;
		if (seen !== want)
		begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, seen, want);
		end
	endtask

	task results();
		if (err_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task acc(input logic wr, input logic cont, input logic [7:0] a, input logic [23:0] d, input logic [23:0] want);
		exp_q.push_back(want);
		tof_link_host_inst.access(wr, cont, a, d);
	endtask

	// ==========================================
	// reply watcher and pulse counters
	always @(posedge link_clock)
		if (link_done === 1'b1)
			check(link_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 24'hxxxxxx);

	// random clock enable while ce_rand is set
	always @(posedge clock)
		clock_enable <= ce_rand ? ($urandom_range(3) != 0) : 1'b1;

	always @(posedge clock)
	begin
		if (capture_start === 1'b1)
			starts <= starts + 1;
		if (soft_reset_pulse === 1'b1)
			resets <= resets + 1;
	end

	initial
	begin
		#60000;
		err_count++;
		results();
	end

	// ==========================================
	// main sequence
	initial
	begin
		void'($urandom(32'h56d79198));
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		link_rst_n <= 1'b1;
		repeat (3) @(posedge link_clock);
		acc(0, 0, G, 24'h000000, tof_ctrl_pkg::GLOBAL_RESET);
		acc(0, 0, 8'h01, 24'h000000, 24'h000000);
		tof_link_host_inst.raw = 1'b1;
		repeat (6)
		begin
			v = 24'($urandom()) & 24'h7ffffe;
			acc(1, 0, G, v, v & tof_ctrl_pkg::GLOBAL_WRITE_MASK);
			check(24'({slave_forward_enable, aux_host_bypass, continuous_slave_access}), 24'({v[22], v[21], v[6]}));
		end
		ce_rand = 1'b1;
		for (int i = 0; i < 12; i++)
		begin
			calib[i] = 24'($urandom());
			acc(1, 0, caddr[i], calib[i], calib[i]);
		end
		for (int i = 0; i < 12; i++)
			acc(0, 0, caddr[i], 24'h000000, calib[i]);
		ce_rand = 1'b0;
		acc(1, 0, 8'hb3, 24'hffffff, 24'h000000);
		acc(1, 0, G, 24'h000040, 24'h000040);
		acc(0, 0, 8'hab, 24'h000000, calib[0]);
		acc(0, 1, 8'($urandom()), 24'h000000, calib[1]);
		v = 24'($urandom());
		acc(1, 1, 8'($urandom()), v, v);
		acc(0, 0, 8'had, 24'h000000, v);
		acc(1, 0, G, 24'h000000, 24'h000000);
		acc(0, 0, 8'hab, 24'h000000, calib[0]);
		acc(1, 1, 8'hab, 24'h5a5a5a, 24'h000000);
		acc(0, 0, 8'hac, 24'h000000, calib[1]);
		tof_link_host_inst.cap_delay = 200;
		acc(1, 0, G, 24'h800000, 24'h800000);
		check(24'(starts), 24'h000001);
		repeat (300) @(posedge clock);
		acc(0, 0, G, 24'h000000, 24'h000000);
		acc(1, 0, G, 24'he00041, 24'h000000);
		check(24'(resets), 24'h000001);
		check(24'(starts), 24'h000001);
		check(24'({slave_forward_enable, aux_host_bypass, continuous_slave_access}), 24'h000000);
		acc(0, 0, G, 24'h000000, 24'h000000);
		acc(0, 0, 8'hab, 24'h000000, calib[0]);
		acc(1, 0, G, 24'h400040, 24'h400040);
		@(posedge clock);
		rst_n <= 1'b0;
		link_rst_n <= 1'b0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		link_rst_n <= 1'b1;
		repeat (3) @(posedge link_clock);
		check(24'({slave_forward_enable, aux_host_bypass, continuous_slave_access}), 24'h000000);
		acc(0, 0, G, 24'h000000, tof_ctrl_pkg::GLOBAL_RESET);
		acc(0, 1, G, 24'h000000, 24'h000000);
		@(posedge link_clock);
		check(24'(exp_q.size()), 24'h000000);
		results();
	end
endmodule
`default_nettype wire
